// [verilog/reset_init_pkg.sv]
// constants, tables and carriers for the reset and wake-up register group
package reset_init_pkg;

    localparam int ADDR_W = 6;

    // register indices on the plain register port
    localparam logic [5:0] IDX_POINTER1_HIGH  = 6'h00;
    localparam logic [5:0] IDX_POINTER1_LOW   = 6'h01;
    localparam logic [5:0] IDX_BANK_SELECT    = 6'h02;
    localparam logic [5:0] IDX_POINTER2_HIGH  = 6'h03;
    localparam logic [5:0] IDX_POINTER2_LOW   = 6'h04;
    localparam logic [5:0] IDX_ALU_FLAGS      = 6'h05;
    localparam logic [5:0] IDX_T0_COUNT_HIGH  = 6'h06;
    localparam logic [5:0] IDX_T0_COUNT_LOW   = 6'h07;
    localparam logic [5:0] IDX_T0_CONTROL     = 6'h08;
    localparam logic [5:0] IDX_OSC_CONTROL    = 6'h09;
    localparam logic [5:0] IDX_VDET_CONTROL   = 6'h0A;
    localparam logic [5:0] IDX_WDOG_CONTROL   = 6'h0B;
    localparam logic [5:0] IDX_RESET_CAUSE    = 6'h0C;
    localparam logic [5:0] IDX_T1_COUNT_HIGH  = 6'h0D;
    localparam logic [5:0] IDX_T1_COUNT_LOW   = 6'h0E;
    localparam logic [5:0] IDX_T1_CONTROL     = 6'h0F;
    localparam logic [5:0] IDX_T2_COUNT       = 6'h10;
    localparam logic [5:0] IDX_T2_PERIOD      = 6'h11;
    localparam logic [5:0] IDX_T2_CONTROL     = 6'h12;
    localparam logic [5:0] IDX_SER_BUFFER     = 6'h13;
    localparam logic [5:0] IDX_SER_ADDR_BAUD  = 6'h14;
    localparam logic [5:0] IDX_SER_STATE      = 6'h15;
    localparam logic [5:0] IDX_SER_CONTROL1   = 6'h16;
    localparam logic [5:0] IDX_SER_CONTROL2   = 6'h17;
    localparam logic [5:0] IDX_PORT_A_LATCH   = 6'h18;
    localparam logic [5:0] IDX_PORT_A_DIR     = 6'h19;
    localparam int         TABLE_REGS         = 26;
    localparam logic [5:0] IDX_PORT_A_PINS    = 6'h1A;
    localparam logic [5:0] IDX_IRQ_FLAGS      = 6'h1B;
    localparam logic [5:0] IDX_STACK_UPPER    = 6'h1C;
    localparam logic [5:0] IDX_STACK_HIGH     = 6'h1D;
    localparam logic [5:0] IDX_STACK_LOW      = 6'h1E;
    localparam logic [5:0] IDX_STACK_POINTER  = 6'h1F;
    localparam logic [5:0] IDX_EVENT_STATUS   = 6'h20;
    localparam logic [5:0] IDX_EVENT_MASK     = 6'h21;

    // port A bits that exist only when the oscillator frees them
    localparam logic [7:0] PORT_A_OSC_BITS = 8'hC0;

    // vector addresses and event status bits
    localparam logic [20:0] VECTOR_HIGH = 21'h000008;
    localparam logic [20:0] VECTOR_LOW  = 21'h000018;
    localparam int EV_POWER_ON = 0;
    localparam int EV_RESET    = 1;
    localparam int EV_WAKE     = 2;
    localparam int EV_VECTOR   = 3;
    localparam int EV_W        = 4;

    // per register: implemented bits, then force mask, forced value and
    // condition mask for power-on, other reset and wake-up in turn
    typedef struct packed {
        logic [7:0] impl;
        logic [7:0] porMask;
        logic [7:0] porVal;
        logic [7:0] porQ;
        logic [7:0] rstMask;
        logic [7:0] rstVal;
        logic [7:0] rstQ;
        logic [7:0] wakeMask;
        logic [7:0] wakeVal;
        logic [7:0] wakeQ;
    } regInit_t;

    localparam regInit_t INIT_TABLE [TABLE_REGS] = '{
        '{8'h0F,8'h0F,8'h00,8'h00,8'h0F,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'h0F,8'h0F,8'h00,8'h00,8'h0F,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'h0F,8'h0F,8'h00,8'h00,8'h0F,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'h1F,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'hFF,8'h00,8'h00,8'hFF,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'hFF,8'hFF,8'h00,8'hFF,8'hFF,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'hF7,8'h40,8'h08,8'hF7,8'h40,8'h08,8'h00,8'h00,8'h02},
        '{8'hBF,8'hBF,8'h05,8'h00,8'hBF,8'h05,8'h00,8'h00,8'h00,8'h00},
        '{8'h01,8'h01,8'h00,8'h00,8'h01,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hDF,8'h9D,8'h1C,8'h42,8'h80,8'h00,8'h5C,8'h00,8'h00,8'h4C},
        '{8'hFF,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'hFF,8'h00,8'h00,8'h40,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'hFF,8'h00,8'h00,8'hFF,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'hFF,8'hFF,8'h00,8'hFF,8'hFF,8'h00,8'hFF,8'hFF,8'h00},
        '{8'h7F,8'h7F,8'h00,8'h00,8'h7F,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'hFF,8'h00,8'h00,8'hFF,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'hFF,8'h00,8'h00,8'hFF,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'hFF,8'h00,8'h00,8'hFF,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'hFF,8'h00,8'h00,8'hFF,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00},
        '{8'hFF,8'hFF,8'hFF,8'h00,8'hFF,8'hFF,8'h00,8'h00,8'h00,8'h00}
    };

    typedef struct packed {
        logic       valid;
        logic       byInterrupt;
        logic       highPriority;
        logic [7:0] cause;
    } wakeReq_t;

    typedef struct packed {
        logic        load;
        logic [20:0] addr;
    } vectorOut_t;

endpackage : reset_init_pkg

// [verilog/reset_init_values.sv]
// reset and wake-up initialisation of the pointer, timer and serial registers
//
// Contract
// - interrupt wake-up with either global enable loads PC with vector.
// - that wake-up copies current PC into the three stack top bytes.
// - that wake-up advances the return stack pointer by one.
// - a wake-up sets its cause bits in the interrupt flags, others kept.
// - port A bits 6 and 7 exist only when oscillator mode frees them.
// - port A bits 6 and 7 read zero when not port pins.
// - unimplemented bits read zero under every condition.
// - timer 2 period forced to all ones on every reset and wake-up.
// - timer 0 control all ones on resets, kept on wake-up.
// - timer 1 control clears on power-on; other resets clear bit 6 only.
// - oscillator control resets to 0100 q000; wake-up loads q into bit 1 only.
// - voltage-detect control resets to 0-00 0101, kept on wake-up.
// - reset-cause control loads 0q-1 11q0 or 0q-q qquu per reset.
// - timer 2 control clears seven bits on reset, kept on wake-up.
`timescale 1ns/100ps

module reset_init_values
    import reset_init_pkg::*;
#(
    parameter int PC_W = 21,
    parameter int SP_W = 5
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [7:0]        regWdata,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [7:0]        regRdata,
    input  wire logic              powerOnEvent,
    input  wire logic              otherResetEvent,
    input  wire wakeReq_t          wakeReq,
    input  wire logic              highPriorityGlobalIrqEnable,
    input  wire logic              lowPriorityGlobalIrqEnable,
    input  wire logic [PC_W-1:0]   programCounter,
    input  wire logic              oscFreesPortPins,
    input  wire logic [7:0]        portAPins,
    input  wire logic [7:0]        oscCondition,
    input  wire logic [7:0]        resetCauseCondition,
    output vectorOut_t             pcVector,
    output logic      [7:0]        irqFlags,
    output logic      [SP_W-1:0]   stackPointer,
    output logic                   irq
);

    // stack top byte split and read mux assume a 21-bit pc
    if (PC_W != 21 || SP_W < 1 || SP_W > 8) begin : g_bad_width
        $error("reset_init_values: unsupported PC_W or SP_W");
    end

    typedef enum {
        EVT_NONE,
        EVT_POWER_ON,
        EVT_RESET,
        EVT_WAKE
    } initEvent_t;

    logic [7:0]      regFile_ff [TABLE_REGS];
    logic [7:0]      irqFlags_ff;
    logic [PC_W-1:0] stackTop_ff;
    logic [SP_W-1:0] stackPtr_ff;
    logic [EV_W-1:0] evStatus_ff;
    logic [EV_W-1:0] evMask_ff;
    logic [7:0]      rdata_ff;
    logic            irq_ff;
    vectorOut_t      vector_ff;
    initEvent_t      event_w;
    logic            vectorTake;
    logic [7:0]      portMask;

    // srst counts as power-on; power-on outranks other resets, which
    // outrank wake-up, so a coincident wake is folded into the reset
    always_comb begin
        if (srst || powerOnEvent) begin
            event_w = EVT_POWER_ON;
        end else if (otherResetEvent) begin
            event_w = EVT_RESET;
        end else if (wakeReq.valid) begin
            event_w = EVT_WAKE;
        end else begin
            event_w = EVT_NONE;
        end
    end

    assign vectorTake = (event_w == EVT_WAKE) && wakeReq.byInterrupt
        && (highPriorityGlobalIrqEnable || lowPriorityGlobalIrqEnable);

    // pins 6 and 7 vanish when the oscillator uses them
    assign portMask = oscFreesPortPins ? 8'hFF : ~PORT_A_OSC_BITS;

    function automatic logic isPortA(input logic [ADDR_W-1:0] a);
        isPortA = (a == IDX_PORT_A_LATCH) || (a == IDX_PORT_A_DIR)
            || (a == IDX_PORT_A_PINS);
    endfunction : isPortA

    // one table entry applied to one register for one event
    function automatic logic [7:0] applyInit(
        input logic [7:0] cur,
        input regInit_t   t,
        input initEvent_t ev,
        input logic [7:0] cond
    );
        logic [7:0] m;
        logic [7:0] v;
        logic [7:0] q;
        m = 8'h00;
        v = 8'h00;
        q = 8'h00;
        case (ev)
            EVT_POWER_ON: begin
                m = t.porMask;
                v = t.porVal;
                q = t.porQ;
            end
            EVT_RESET: begin
                m = t.rstMask;
                v = t.rstVal;
                q = t.rstQ;
            end
            EVT_WAKE: begin
                m = t.wakeMask;
                v = t.wakeVal;
                q = t.wakeQ;
            end
            default: begin
                m = 8'h00;
            end
        endcase
        applyInit = (cur & ~m) | (v & m);
        applyInit = (applyInit & ~q) | (cond & q);
        applyInit = applyInit & t.impl;
    endfunction : applyInit

    // every table register uses the same update; masks carry the values
    // of timer, oscillator, detector, cause and serial registers alike
    genvar gi;
    generate
        for (gi = 0; gi < TABLE_REGS; gi++) begin : g_reg
            localparam logic [5:0] IDX = 6'(gi);
            logic [7:0] cond;
            logic [7:0] wmask;
            assign cond = (IDX == IDX_OSC_CONTROL) ? oscCondition
                : (IDX == IDX_RESET_CAUSE) ? resetCauseCondition
                : 8'h00;
            assign wmask = ((IDX == IDX_PORT_A_LATCH)
                || (IDX == IDX_PORT_A_DIR)) ? portMask : 8'hFF;
            always_ff @(posedge clk) begin
                if (event_w != EVT_NONE) begin
                    regFile_ff[gi] <= applyInit(regFile_ff[gi],
                        INIT_TABLE[gi], event_w, cond);
                end else if (regWrite && regAddr == ADDR_W'(IDX)) begin
                    regFile_ff[gi] <= regWdata & INIT_TABLE[gi].impl
                        & wmask;
                end
            end
        end
    endgenerate
    // are held in the table rows above

    // wake cause bits are sticky; hardware set beats a software clear
    always_ff @(posedge clk) begin
        if (event_w == EVT_POWER_ON || event_w == EVT_RESET) begin
            irqFlags_ff <= 8'h00;
        end else begin
            irqFlags_ff <= (irqFlags_ff
                & ~((regWrite && regAddr == IDX_IRQ_FLAGS) ? regWdata
                    : 8'h00))
                | ((event_w == EVT_WAKE) ? wakeReq.cause : 8'h00);
        end
    end

    always_ff @(posedge clk) begin
        if (event_w == EVT_POWER_ON || event_w == EVT_RESET) begin
            stackTop_ff <= '0;
        end else if (vectorTake) begin
            stackTop_ff <= programCounter;
        end
    end

    // the pointer simply wraps; overflow handling belongs to the core
    always_ff @(posedge clk) begin
        if (event_w == EVT_POWER_ON || event_w == EVT_RESET) begin
            stackPtr_ff <= '0;
        end else if (vectorTake) begin
            stackPtr_ff <= stackPtr_ff + SP_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            vector_ff <= '0;
        end else begin
            vector_ff.load <= vectorTake;
            if (vectorTake) begin
                vector_ff.addr <= wakeReq.highPriority ? VECTOR_HIGH
                    : VECTOR_LOW;
            end
        end
    end

    // event status: sticky, write one to clear, set wins over clear
    logic [EV_W-1:0] evSet;
    always_comb begin
        evSet              = '0;
        evSet[EV_POWER_ON] = (event_w == EVT_POWER_ON);
        evSet[EV_RESET]    = (event_w == EVT_RESET);
        evSet[EV_WAKE]     = (event_w == EVT_WAKE);
        evSet[EV_VECTOR]   = vectorTake;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            evStatus_ff <= '0;
        end else begin
            evStatus_ff <= (evStatus_ff
                & ~((regWrite && regAddr == IDX_EVENT_STATUS)
                    ? regWdata[EV_W-1:0] : '0)) | evSet;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            evMask_ff <= '0;
        end else if (regWrite && regAddr == IDX_EVENT_MASK) begin
            evMask_ff <= regWdata[EV_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(evStatus_ff & evMask_ff);
        end
    end

    // read data stands in the cycle after the read strobe only
    logic [7:0] rdMux;
    always_comb begin
        rdMux = 8'h00;
        if (regAddr < ADDR_W'(TABLE_REGS)) begin
            rdMux = regFile_ff[regAddr[4:0]];
        end else if (regAddr == IDX_PORT_A_PINS) begin
            rdMux = portAPins;
        end else if (regAddr == IDX_IRQ_FLAGS) begin
            rdMux = irqFlags_ff;
        end else if (regAddr == IDX_STACK_UPPER) begin
            rdMux = {3'h0, stackTop_ff[20:16]};
        end else if (regAddr == IDX_STACK_HIGH) begin
            rdMux = stackTop_ff[15:8];
        end else if (regAddr == IDX_STACK_LOW) begin
            rdMux = stackTop_ff[7:0];
        end else if (regAddr == IDX_STACK_POINTER) begin
            rdMux = 8'(stackPtr_ff);
        end else if (regAddr == IDX_EVENT_STATUS) begin
            rdMux = 8'(evStatus_ff);
        end else if (regAddr == IDX_EVENT_MASK) begin
            rdMux = 8'(evMask_ff);
        end
        if (isPortA(regAddr)) begin
            rdMux = rdMux & portMask;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= regRead ? rdMux : 8'h00;
        end
    end

    assign regRdata     = rdata_ff;
    assign pcVector     = vector_ff;
    assign irqFlags     = irqFlags_ff;
    assign stackPointer = stackPtr_ff;
    assign irq          = irq_ff;

endmodule : reset_init_values

// [sim/reset_init_values_chk.sv]
// concurrent checks on the ports of the reset and wake-up register group
`timescale 1ns/100ps
module reset_init_values_chk
    import reset_init_pkg::*;
#(
    parameter int PC_W = 21,
    parameter int SP_W = 5
) (
    input wire logic              clk,
    input wire logic              srst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [7:0]        regWdata,
    input wire logic              regWrite,
    input wire logic              regRead,
    input wire logic [7:0]        regRdata,
    input wire logic              powerOnEvent,
    input wire logic              otherResetEvent,
    input wire wakeReq_t          wakeReq,
    input wire logic              highPriorityGlobalIrqEnable,
    input wire logic              lowPriorityGlobalIrqEnable,
    input wire logic [PC_W-1:0]   programCounter,
    input wire logic              oscFreesPortPins,
    input wire logic [7:0]        portAPins,
    input wire logic [7:0]        oscCondition,
    input wire logic [7:0]        resetCauseCondition,
    input wire vectorOut_t        pcVector,
    input wire logic [7:0]        irqFlags,
    input wire logic [SP_W-1:0]   stackPointer,
    input wire logic              irq
);
    logic anyRst;
    logic vecd;
    logic wakeOnly;
    logic port_a_pins;
    assign anyRst = powerOnEvent | otherResetEvent | srst;
    assign wakeOnly = wakeReq.valid & !anyRst;
    // a reset in the same cycle outranks the wake, so no vectoring then
    assign vecd = wakeOnly & wakeReq.byInterrupt
                & (highPriorityGlobalIrqEnable | lowPriorityGlobalIrqEnable);
    assign port_a_pins = regAddr == IDX_PORT_A_PINS
                 || regAddr == IDX_PORT_A_LATCH || regAddr == IDX_PORT_A_DIR;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_vector_cause: assert property (pcVector.load == $past(vecd))
        else $error("vector load without interrupt wake");
    a_vector_addr: assert property (pcVector.load |-> pcVector.addr ==
        ($past(wakeReq.highPriority) ? VECTOR_HIGH : VECTOR_LOW))
        else $error("wrong vector address");
    a_stack_advance: assert property ($past(vecd) |->
        stackPointer == SP_W'($past(stackPointer) + 1'b1))
        else $error("stack pointer not advanced");
    a_stack_hold: assert property (!$past(vecd) && !$past(anyRst)
        |-> $stable(stackPointer)) else $error("stack pointer moved");
    a_flags_set: assert property ($past(wakeOnly) |->
        (irqFlags & $past(wakeReq.cause)) == $past(wakeReq.cause))
        else $error("wake cause flag missing");
    a_flags_kept: assert property ($past(wakeOnly) &&
        !$past(regWrite && regAddr == IDX_IRQ_FLAGS)
        |-> (irqFlags & $past(irqFlags)) == $past(irqFlags))
        else $error("wake lost other flags");
    a_reset_clears: assert property ($past(otherResetEvent) |->
        irqFlags == 8'h00 && stackPointer == '0)
        else $error("flags or stack kept over reset");
    a_read_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
        else $error("read data outside its cycle");
    a_port_a_high: assert property ($past(regRead && port_a_pins
        && !oscFreesPortPins) |-> regRdata[7:6] == 2'b00)
        else $error("port A bits 6 7 not zero");
    a_unimpl_zero: assert property ($past(regRead) |->
        !($past(regAddr) == IDX_VDET_CONTROL && regRdata[6])
        && !($past(regAddr) == IDX_T2_CONTROL && regRdata[7])
        && !($past(regAddr) == IDX_RESET_CAUSE && regRdata[5]))
        else $error("unimplemented bit reads one");
    a_unmapped_zero: assert property ($past(regRead) &&
        $past(regAddr) > IDX_EVENT_MASK |-> regRdata == 8'h00)
        else $error("unmapped index reads nonzero");
    c_vector: cover property (pcVector.load);
    c_other_reset: cover property (otherResetEvent);
    c_irq: cover property ($rose(irq));
endmodule : reset_init_values_chk

// [sim/core_model.sv]
// behavioural core: reset sources, wake-up requests and a running PC
`timescale 1ns/100ps
module core_model
    import reset_init_pkg::*;
(
    input  wire logic   clk,
    output logic        powerOnEvent,
    output logic        otherResetEvent,
    output wakeReq_t    wakeReq,
    output logic        gieHigh,
    output logic        gieLow,
    output logic [20:0] programCounter
);
    logic [20:0] pcCnt = 21'h1ABCD0;
    logic [20:0] lastPc;
    initial begin
        {powerOnEvent, otherResetEvent, gieHigh, gieLow} = 4'h0;
        wakeReq = '0;
    end
    // the pc never stands, so a stale stacked value cannot pass
    always @(posedge clk) begin
        pcCnt <= pcCnt + 21'h000002;
    end
    assign programCounter = pcCnt;
    task fire(input logic por);
        @(posedge clk);
        powerOnEvent <= por;
        otherResetEvent <= !por;
        @(posedge clk);
        {powerOnEvent, otherResetEvent} <= 2'b00;
    endtask : fire
    task wake(input logic intr, hp, eh, el, input logic [7:0] cause);
        @(posedge clk);
        wakeReq <= '{1'b1, intr, hp, cause};
        gieHigh <= eh;
        gieLow <= el;
        @(posedge clk);
        lastPc = pcCnt;
        wakeReq <= '0;
    endtask : wake
endmodule : core_model

// [sim/reset_init_values_tb_top.sv]
// self-checking bench for the reset and wake-up register group
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module reset_init_values_tb_top;
    import reset_init_pkg::*;
    logic clk = 1'b0, srst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic [5:0] regAddr = 6'h00;
    logic [7:0] regWdata = 8'h00, regRdata, irqFlags, portAPins = 8'h00;
    logic [7:0] oscCondition = 8'h08, resetCauseCondition = 8'hFF;
    logic oscFreesPortPins = 1'b0, irq, powerOnEvent, otherResetEvent;
    logic gieHigh, gieLow;
    logic [20:0] programCounter, pc;
    logic [4:0] stackPointer;
    wakeReq_t wakeReq;
    vectorOut_t pcVector;
    int error_cnt = 0, checks = 0;
    reset_init_values i_reset_init_values (.clk(clk), .srst(srst),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .powerOnEvent(powerOnEvent),
        .otherResetEvent(otherResetEvent), .wakeReq(wakeReq),
        .highPriorityGlobalIrqEnable(gieHigh),
        .lowPriorityGlobalIrqEnable(gieLow), .programCounter(programCounter),
        .oscFreesPortPins(oscFreesPortPins), .portAPins(portAPins),
        .oscCondition(oscCondition), .pcVector(pcVector),
        .resetCauseCondition(resetCauseCondition), .irqFlags(irqFlags),
        .stackPointer(stackPointer), .irq(irq));
    core_model i_core_model (.clk(clk), .powerOnEvent(powerOnEvent),
        .otherResetEvent(otherResetEvent), .wakeReq(wakeReq),
        .gieHigh(gieHigh), .gieLow(gieLow), .programCounter(programCounter));
    initial begin
        forever #2 clk = ~clk;
    end
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    task rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        `CHK(regRdata, e)
    endtask : rd
    task tally_and_finish;
        if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        i_core_model.fire(1'b1);
        rd(IDX_T0_CONTROL, 8'hFF);
        rd(IDX_T2_PERIOD, 8'hFF);
        rd(IDX_T1_CONTROL, 8'h00);
        rd(IDX_OSC_CONTROL, 8'h48);
        rd(IDX_VDET_CONTROL, 8'h05);
        rd(IDX_RESET_CAUSE, 8'h5E);
        rd(IDX_T2_CONTROL, 8'h00);
        rd(IDX_POINTER1_HIGH, 8'h00);
        wr(IDX_T0_CONTROL, 8'h12);
        wr(IDX_T1_CONTROL, 8'hFF);
        wr(IDX_T2_PERIOD, 8'h34);
        wr(IDX_T2_CONTROL, 8'hFF);
        wr(IDX_VDET_CONTROL, 8'hFF);
        wr(IDX_POINTER1_LOW, 8'hA5);
        wr(IDX_POINTER1_HIGH, 8'h0F);
        rd(IDX_T2_CONTROL, 8'h7F);
        oscCondition <= 8'h02;
        // watchdog wake: no interrupt, so no vectoring either
        i_core_model.wake(1'b0, 1'b0, 1'b1, 1'b1, 8'h01);
        #1 `CHK(irqFlags, 8'h01)
        rd(IDX_T0_CONTROL, 8'h12);
        rd(IDX_T2_PERIOD, 8'hFF);
        rd(IDX_T2_CONTROL, 8'h7F);
        rd(IDX_VDET_CONTROL, 8'hBF);
        rd(IDX_OSC_CONTROL, 8'h4A);
        resetCauseCondition <= 8'h00;
        i_core_model.fire(1'b0);
        rd(IDX_RESET_CAUSE, 8'h02);
        rd(IDX_T1_CONTROL, 8'hBF);
        rd(IDX_T0_CONTROL, 8'hFF);
        rd(IDX_OSC_CONTROL, 8'h40);
        rd(IDX_POINTER1_LOW, 8'hA5);
        rd(IDX_POINTER1_HIGH, 8'h00);
        i_core_model.wake(1'b1, 1'b1, 1'b1, 1'b0, 8'h02);
        pc = i_core_model.lastPc;
        #1 `CHK(pcVector, {1'b1, VECTOR_HIGH})
        `CHK(irqFlags, 8'h02)
        rd(IDX_STACK_UPPER, {3'h0, pc[20:16]});
        rd(IDX_STACK_HIGH, pc[15:8]);
        rd(IDX_STACK_LOW, pc[7:0]);
        rd(IDX_STACK_POINTER, 8'h01);
        i_core_model.wake(1'b1, 1'b0, 1'b0, 1'b1, 8'h10);
        #1 `CHK(pcVector, {1'b1, VECTOR_LOW})
        `CHK(irqFlags, 8'h12)
        i_core_model.wake(1'b1, 1'b1, 1'b0, 1'b0, 8'h20);
        #1 `CHK(pcVector.load, 1'b0)
        rd(IDX_STACK_POINTER, 8'h02);
        `CHK(stackPointer, 5'h02)
        wr(IDX_PORT_A_LATCH, 8'hFF);
        rd(IDX_PORT_A_LATCH, 8'h3F);
        portAPins <= 8'hFF;
        rd(IDX_PORT_A_PINS, 8'h3F);
        oscFreesPortPins <= 1'b1;
        wr(IDX_PORT_A_LATCH, 8'hFF);
        rd(IDX_PORT_A_LATCH, 8'hFF);
        rd(IDX_PORT_A_PINS, 8'hFF);
        wr(IDX_EVENT_MASK, 8'h04);
        repeat (2) @(posedge clk);
        #1 `CHK(irq, 1'b1)
        wr(IDX_EVENT_STATUS, 8'h0F);
        repeat (2) @(posedge clk);
        #1 `CHK(irq, 1'b0)
        wr(IDX_IRQ_FLAGS, 8'hFF);
        rd(IDX_IRQ_FLAGS, 8'h00);
        rd(6'h3F, 8'h00);
        // mid-run reset acts as a power-on event
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(IDX_T1_CONTROL, 8'h00);
        rd(IDX_STACK_POINTER, 8'h00);
        `CHK(pcVector, 22'h000000)
        tally_and_finish();
    end
endmodule : reset_init_values_tb_top
bind reset_init_values reset_init_values_chk #(.PC_W(PC_W), .SP_W(SP_W))
    i_reset_init_values_chk (.clk(clk), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .powerOnEvent(powerOnEvent),
    .otherResetEvent(otherResetEvent), .wakeReq(wakeReq),
    .highPriorityGlobalIrqEnable(highPriorityGlobalIrqEnable),
    .lowPriorityGlobalIrqEnable(lowPriorityGlobalIrqEnable),
    .programCounter(programCounter), .oscFreesPortPins(oscFreesPortPins),
    .portAPins(portAPins), .oscCondition(oscCondition),
    .resetCauseCondition(resetCauseCondition), .pcVector(pcVector),
    .irqFlags(irqFlags), .stackPointer(stackPointer), .irq(irq));
